/* File: pkg/ufdc_pkg.sv */
// Constants, types and trigger decoding for the UART FIFO and DMA control block
package ufdc_pkg;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned ADDR_W = 3;
   localparam int unsigned FIFO_DEPTH = 32;
   localparam int unsigned PTR_W = 5;
   localparam int unsigned CNT_W = 6;

   // Register offsets
   localparam logic [2:0] OFS_HOLDING = 3'h0;
   localparam logic [2:0] OFS_INTERRUPT_MASK = 3'h1;
   localparam logic [2:0] OFS_FIFO_CONTROL = 3'h2;
   localparam logic [2:0] OFS_LINE_STATUS = 3'h5;
   localparam logic [2:0] OFS_RX_LEVEL = 3'h6;
   localparam logic [2:0] OFS_TX_LEVEL = 3'h7;

   // fifo_control fields
   localparam int unsigned FC_ENABLE = 0;
   localparam int unsigned FC_RX_CLEAR = 1;
   localparam int unsigned FC_TX_CLEAR = 2;
   localparam int unsigned FC_DMA_MODE = 3;
   localparam int unsigned FC_TX_TRIG_LO = 4;
   localparam int unsigned FC_RX_TRIG_LO = 6;

   // line_status fields
   localparam int unsigned LS_DATA_READY = 0;
   localparam int unsigned LS_OVERRUN = 1;
   localparam int unsigned LS_PARITY = 2;
   localparam int unsigned LS_FRAMING = 3;
   localparam int unsigned LS_BREAK = 4;
   localparam int unsigned LS_TX_EMPTY = 5;
   localparam int unsigned LS_TX_IDLE = 6;
   localparam int unsigned LS_FIFO_ERROR = 7;

   // Reset values
   localparam logic [1:0] RST_TRIG_SEL = 2'h0;
   localparam logic [3:0] RST_INT_MASK = 4'h0;
   localparam logic RST_DMA_MODE = 1'b0;
   localparam logic RST_FIFO_EN = 1'b0;

   // Trigger levels in characters
   localparam logic [5:0] RX_TRIG_0 = 6'h08;
   localparam logic [5:0] RX_TRIG_1 = 6'h10;
   localparam logic [5:0] RX_TRIG_2 = 6'h18;
   localparam logic [5:0] RX_TRIG_3 = 6'h1c;
   localparam logic [5:0] TX_TRIG_0 = 6'h10;
   localparam logic [5:0] TX_TRIG_1 = 6'h08;
   localparam logic [5:0] TX_TRIG_2 = 6'h18;
   localparam logic [5:0] TX_TRIG_3 = 6'h1e;

   typedef struct packed {
      logic brk;
      logic framing;
      logic parity;
      logic [7:0] data;
   } ufdc_rx_char_s;

   function automatic logic [5:0] ufdc_rx_trig(input logic [1:0] sel);
      case (sel)
         2'h0: ufdc_rx_trig = RX_TRIG_0;
         2'h1: ufdc_rx_trig = RX_TRIG_1;
         2'h2: ufdc_rx_trig = RX_TRIG_2;
         default: ufdc_rx_trig = RX_TRIG_3;
      endcase
   endfunction

   function automatic logic [5:0] ufdc_tx_trig(input logic [1:0] sel);
      case (sel)
         2'h0: ufdc_tx_trig = TX_TRIG_0;
         2'h1: ufdc_tx_trig = TX_TRIG_1;
         2'h2: ufdc_tx_trig = TX_TRIG_2;
         default: ufdc_tx_trig = TX_TRIG_3;
      endcase
   endfunction
endpackage

/* File: design/ufdc_fifo.sv */
// Character FIFO with clear, fill count and single-entry holding mode
`timescale 1ns/1ps
module ufdc_fifo #(
   parameter int unsigned WIDTH = 8
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clear,
   input wire logic single,
   input wire logic push,
   input wire logic [WIDTH-1:0] push_data,
   input wire logic pop,
   output logic [WIDTH-1:0] head,
   output logic [ufdc_pkg::CNT_W-1:0] count,
   output logic full,
   output logic empty
);
   logic [WIDTH-1:0] mem [ufdc_pkg::FIFO_DEPTH];
   logic [ufdc_pkg::PTR_W-1:0] wr_ptr_reg, wr_ptr_next;
   logic [ufdc_pkg::PTR_W-1:0] rd_ptr_reg, rd_ptr_next;
   logic [ufdc_pkg::CNT_W-1:0] count_reg, count_next;
   logic push_ok, pop_ok;

   // Holding-register mode keeps the same storage but stops at one entry
   assign full = single ? (count_reg != '0) : (count_reg == ufdc_pkg::CNT_W'(ufdc_pkg::FIFO_DEPTH));
   assign empty = (count_reg == '0);
   assign push_ok = push && !full;
   assign pop_ok = pop && !empty;
   assign head = mem[rd_ptr_reg];
   assign count = count_reg;

   always_comb begin
      wr_ptr_next = wr_ptr_reg;
      rd_ptr_next = rd_ptr_reg;
      count_next = count_reg;
      if (clear) begin
         wr_ptr_next = '0;
         rd_ptr_next = '0;
         count_next = '0;
      end else begin
         if (push_ok) begin
            wr_ptr_next = wr_ptr_reg + 1'b1;
         end
         if (pop_ok) begin
            rd_ptr_next = rd_ptr_reg + 1'b1;
         end
         count_next = count_reg + ufdc_pkg::CNT_W'(push_ok) - ufdc_pkg::CNT_W'(pop_ok);
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         wr_ptr_reg <= wr_ptr_next;
         rd_ptr_reg <= rd_ptr_next;
         count_reg <= count_next;
      end
   end

   // Storage needs no reset; only the pointers and the count define validity
   always_ff @(posedge clk) begin
      if (push_ok && !clear) begin
         mem[wr_ptr_reg] <= push_data;
      end
   end
endmodule

/* File: design/ufdc_top.sv */
// FIFO control, line status and DMA ready signalling for one UART channel
`timescale 1ns/1ps
module ufdc_top (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [ufdc_pkg::ADDR_W-1:0] bus_addr,
   input wire logic [ufdc_pkg::DATA_W-1:0] bus_wdata,
   input wire logic bus_write,
   input wire logic bus_read,
   output logic [ufdc_pkg::DATA_W-1:0] bus_rdata,
   input wire logic rx_char_valid,
   input wire ufdc_pkg::ufdc_rx_char_s rx_char,
   input wire logic rx_timeout,
   output logic tx_char_valid,
   output logic [ufdc_pkg::DATA_W-1:0] tx_char_data,
   input wire logic tx_char_ready,
   input wire logic tx_shift_busy,
   output logic tx_dma_ready_n,
   output logic rx_dma_ready_n,
   output logic rx_data_int,
   output logic tx_empty_int,
   output logic line_status_int
);
   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic fifo_en_reg, fifo_en_next;
   logic dma_mode_reg, dma_mode_next;
   logic [1:0] rx_trig_sel_reg, rx_trig_sel_next;
   logic [1:0] tx_trig_sel_reg, tx_trig_sel_next;
   logic [3:0] interrupt_mask_reg, interrupt_mask_next;
   logic overrun_reg, overrun_next;
   logic [ufdc_pkg::CNT_W-1:0] err_count_reg, err_count_next;
   logic tx_hold_reg, tx_hold_next;
   logic rx_act_reg, rx_act_next;
   logic [ufdc_pkg::DATA_W-1:0] rdata_reg, rdata_next;
   logic [ufdc_pkg::DATA_W-1:0] line_status;
   logic fc_write, mask_write, hold_write, hold_read, ls_read;
   logic rx_clear, tx_clear, en_change;
   logic rx_push, rx_pop, tx_push, tx_pop;
   logic rx_full, rx_empty, tx_full, tx_empty;
   logic [ufdc_pkg::CNT_W-1:0] rx_count, tx_count, rx_trig, tx_trig;
   ufdc_pkg::ufdc_rx_char_s rx_head;
   logic head_err, push_err, fifo_mode1;

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode
   assign fc_write = bus_write && (bus_addr == ufdc_pkg::OFS_FIFO_CONTROL);
   assign mask_write = bus_write && (bus_addr == ufdc_pkg::OFS_INTERRUPT_MASK);
   assign hold_write = bus_write && (bus_addr == ufdc_pkg::OFS_HOLDING);
   assign hold_read = bus_read && (bus_addr == ufdc_pkg::OFS_HOLDING);
   assign ls_read = bus_read && (bus_addr == ufdc_pkg::OFS_LINE_STATUS);

   // Switching the FIFOs on or off also empties them, so no stale entries leak
   assign en_change = fc_write && (bus_wdata[ufdc_pkg::FC_ENABLE] != fifo_en_reg);
   // Clear bits act in the write cycle and are never stored, so they read back as zero
   assign rx_clear = en_change || (fc_write && bus_wdata[ufdc_pkg::FC_ENABLE] && bus_wdata[ufdc_pkg::FC_RX_CLEAR]);
   assign tx_clear = en_change || (fc_write && bus_wdata[ufdc_pkg::FC_ENABLE] && bus_wdata[ufdc_pkg::FC_TX_CLEAR]);

   ////////////////////////////////////////////////////////////////////////////
   // FIFOs
   assign rx_push = rx_char_valid && !rx_full;
   assign rx_pop = hold_read && !rx_empty;
   assign tx_push = hold_write && !tx_full;
   assign tx_pop = tx_char_ready && !tx_empty;

   ufdc_fifo #(.WIDTH($bits(ufdc_pkg::ufdc_rx_char_s))) u_rx_fifo (
      .clk(clk),
      .reset_n(reset_n),
      .clear(rx_clear),
      .single(!fifo_en_reg),
      .push(rx_push),
      .push_data(rx_char),
      .pop(rx_pop),
      .head(rx_head),
      .count(rx_count),
      .full(rx_full),
      .empty(rx_empty)
   );

   ufdc_fifo #(.WIDTH(ufdc_pkg::DATA_W)) u_tx_fifo (
      .clk(clk),
      .reset_n(reset_n),
      .clear(tx_clear),
      .single(!fifo_en_reg),
      .push(tx_push),
      .push_data(bus_wdata),
      .pop(tx_pop),
      .head(tx_char_data),
      .count(tx_count),
      .full(tx_full),
      .empty(tx_empty)
   );

   // The shift register sits outside and is never cleared from here
   assign tx_char_valid = !tx_empty;

   ////////////////////////////////////////////////////////////////////////////
   // Status
   assign rx_trig = ufdc_pkg::ufdc_rx_trig(rx_trig_sel_reg);
   assign tx_trig = ufdc_pkg::ufdc_tx_trig(tx_trig_sel_reg);
   assign head_err = !rx_empty && (rx_head.parity || rx_head.framing || rx_head.brk);
   assign push_err = rx_char.parity || rx_char.framing || rx_char.brk;
   assign fifo_mode1 = fifo_en_reg && dma_mode_reg;

   always_comb begin
      line_status = '0;
      line_status[ufdc_pkg::LS_DATA_READY] = !rx_empty;
      line_status[ufdc_pkg::LS_OVERRUN] = overrun_reg;
      line_status[ufdc_pkg::LS_PARITY] = !rx_empty && rx_head.parity;
      line_status[ufdc_pkg::LS_FRAMING] = !rx_empty && rx_head.framing;
      line_status[ufdc_pkg::LS_BREAK] = !rx_empty && rx_head.brk;
      line_status[ufdc_pkg::LS_TX_EMPTY] = tx_empty;
      line_status[ufdc_pkg::LS_TX_IDLE] = tx_empty && !tx_shift_busy;
      line_status[ufdc_pkg::LS_FIFO_ERROR] = (err_count_reg != '0);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control and status state
   always_comb begin
      fifo_en_next = fifo_en_reg;
      dma_mode_next = dma_mode_reg;
      rx_trig_sel_next = rx_trig_sel_reg;
      tx_trig_sel_next = tx_trig_sel_reg;
      interrupt_mask_next = interrupt_mask_reg;
      overrun_next = overrun_reg;
      err_count_next = err_count_reg;
      if (fc_write) begin
         fifo_en_next = bus_wdata[ufdc_pkg::FC_ENABLE];
         if (bus_wdata[ufdc_pkg::FC_ENABLE]) begin
            dma_mode_next = bus_wdata[ufdc_pkg::FC_DMA_MODE];
            tx_trig_sel_next = bus_wdata[ufdc_pkg::FC_TX_TRIG_LO +: 2];
            rx_trig_sel_next = bus_wdata[ufdc_pkg::FC_RX_TRIG_LO +: 2];
         end
      end
      if (mask_write) begin
         interrupt_mask_next = bus_wdata[3:0];
      end
      // A new overrun in the reading cycle survives the clear
      if (ls_read) begin
         overrun_next = 1'b0;
      end
      if (rx_char_valid && rx_full) begin
         overrun_next = 1'b1;
      end
      if (rx_clear) begin
         err_count_next = '0;
      end else begin
         err_count_next = err_count_reg + ufdc_pkg::CNT_W'(rx_push && push_err)
                          - ufdc_pkg::CNT_W'(rx_pop && head_err);
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         fifo_en_reg <= ufdc_pkg::RST_FIFO_EN;
         dma_mode_reg <= ufdc_pkg::RST_DMA_MODE;
         rx_trig_sel_reg <= ufdc_pkg::RST_TRIG_SEL;
         tx_trig_sel_reg <= ufdc_pkg::RST_TRIG_SEL;
         interrupt_mask_reg <= ufdc_pkg::RST_INT_MASK;
         overrun_reg <= 1'b0;
         err_count_reg <= '0;
      end else begin
         fifo_en_reg <= fifo_en_next;
         dma_mode_reg <= dma_mode_next;
         rx_trig_sel_reg <= rx_trig_sel_next;
         tx_trig_sel_reg <= tx_trig_sel_next;
         interrupt_mask_reg <= interrupt_mask_next;
         overrun_reg <= overrun_next;
         err_count_reg <= err_count_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // DMA ready latches for mode 1
   always_comb begin
      tx_hold_next = tx_hold_reg;
      rx_act_next = rx_act_reg;
      // Hysteresis: stop the controller at full, restart once drained to trigger
      if (tx_full) begin
         tx_hold_next = 1'b1;
      end else if (tx_count <= tx_trig) begin
         tx_hold_next = 1'b0;
      end
      if (rx_empty) begin
         rx_act_next = 1'b0;
      end else if (rx_count >= rx_trig || rx_timeout) begin
         rx_act_next = 1'b1;
      end
      if (!fifo_mode1) begin
         tx_hold_next = 1'b0;
         rx_act_next = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tx_hold_reg <= 1'b0;
         rx_act_reg <= 1'b0;
      end else begin
         tx_hold_reg <= tx_hold_next;
         rx_act_reg <= rx_act_next;
      end
   end

   // Mode 1 outputs also react to the live level so nothing lags a cycle
   // Latches are gated by the live count, or they would hold a pin one cycle past a drain or clear
   assign tx_dma_ready_n = fifo_mode1 ? (tx_full || (tx_hold_reg && tx_count > tx_trig)) : !tx_empty;
   assign rx_dma_ready_n = fifo_mode1 ? !(!rx_empty && (rx_act_reg || rx_count >= rx_trig)) : rx_empty;

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt conditions for the external priority encoder
   assign rx_data_int = interrupt_mask_reg[0] && (fifo_en_reg ? (rx_count >= rx_trig) : !rx_empty);
   assign tx_empty_int = interrupt_mask_reg[1] && (fifo_en_reg ? (tx_count < tx_trig) : tx_empty);
   assign line_status_int = interrupt_mask_reg[2] && (line_status[4:1] != 4'h0);

   ////////////////////////////////////////////////////////////////////////////
   // Read data, valid only in the cycle after the strobe
   always_comb begin
      rdata_next = '0;
      if (bus_read) begin
         case (bus_addr)
            ufdc_pkg::OFS_HOLDING: rdata_next = rx_empty ? 8'h00 : rx_head.data;
            ufdc_pkg::OFS_INTERRUPT_MASK: rdata_next = {4'h0, interrupt_mask_reg};
            ufdc_pkg::OFS_LINE_STATUS: rdata_next = line_status;
            ufdc_pkg::OFS_RX_LEVEL: rdata_next = {2'h0, rx_count};
            ufdc_pkg::OFS_TX_LEVEL: rdata_next = {2'h0, tx_count};
            default: rdata_next = '0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_reg <= '0;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign bus_rdata = rdata_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   property p_ls_ready;
      @(posedge clk) disable iff (!reset_n) ls_read |=> bus_rdata[0] == $past(rx_count != 0);
   endproperty
   a_ls_ready: assert property (p_ls_ready) else $error("data ready bit wrong");

   property p_ls_idle;
      @(posedge clk) disable iff (!reset_n) ls_read |=> bus_rdata[6] == ($past(tx_count == 0) && !$past(tx_shift_busy));
   endproperty
   a_ls_idle: assert property (p_ls_idle) else $error("transmitter idle bit wrong");

   property p_tx_clear;
      @(posedge clk) disable iff (!reset_n) (fc_write && bus_wdata[0] && bus_wdata[2]) |=> tx_count == 0;
   endproperty
   a_tx_clear: assert property (p_tx_clear) else $error("transmit FIFO not emptied");

   property p_rx_clear;
      @(posedge clk) disable iff (!reset_n) (fc_write && bus_wdata[0] && bus_wdata[1]) |=> rx_count == 0;
   endproperty
   a_rx_clear: assert property (p_rx_clear) else $error("receive FIFO not emptied");

   property p_ignore;
      @(posedge clk) disable iff (!reset_n)
         (fc_write && !bus_wdata[0]) |=> $stable(dma_mode_reg) && $stable(rx_trig_sel_reg) && $stable(tx_trig_sel_reg);
   endproperty
   a_ignore: assert property (p_ignore) else $error("control bits taken without enable");

   property p_mode0_ready;
      @(posedge clk) disable iff (!reset_n)
         !fifo_mode1 |-> (rx_dma_ready_n == (rx_count == 0)) && (tx_dma_ready_n == (tx_count != 0));
   endproperty
   a_mode0_ready: assert property (p_mode0_ready) else $error("mode 0 ready pins wrong");

   property p_mode1_full;
      @(posedge clk) disable iff (!reset_n) (fifo_mode1 && tx_count == 6'h20) |-> tx_dma_ready_n;
   endproperty
   a_mode1_full: assert property (p_mode1_full) else $error("transmit ready low while full");

   property p_mode1_rx;
      @(posedge clk) disable iff (!reset_n)
         (fifo_mode1 && !rx_dma_ready_n && rx_count != 0 && !rx_clear && $stable(dma_mode_reg)
          && !(rx_pop && rx_count == 6'h01)) |=> !rx_dma_ready_n;
   endproperty
   a_mode1_rx: assert property (p_mode1_rx) else $error("receive ready released early");

   property p_polled;
      @(posedge clk) disable iff (!reset_n)
         (interrupt_mask_reg == 4'h0) |-> !rx_data_int && !tx_empty_int && !line_status_int;
   endproperty
   a_polled: assert property (p_polled) else $error("interrupt raised in polled mode");
endmodule

/* File: verification/ufdc_line_model.sv */
// Transmit shift register model: takes characters and stays busy a while after each
`timescale 1ns/1ps
module ufdc_line_model (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic stall,
   input wire logic tx_char_valid,
   input wire logic [7:0] tx_char_data,
   output logic tx_char_ready,
   output logic tx_shift_busy
);
   logic [1:0] busy_reg;
   // Ready only when idle, so a slow line backs the FIFO up
   assign tx_char_ready = !stall && busy_reg == 2'h0;
   assign tx_shift_busy = busy_reg != 2'h0;
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         busy_reg <= 2'h0;
      end else if (tx_char_valid && tx_char_ready) begin
         busy_reg <= 2'h3;
      end else if (busy_reg != 2'h0) begin
         busy_reg <= busy_reg - 2'h1;
      end
   end
endmodule

/* File: verification/uart_fifo_dma_control_test.sv */
// Self-checking bench for the FIFO control and DMA ready block
`timescale 1ns/1ps
module uart_fifo_dma_control_test;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [2:0] bus_addr = 3'h0;
   logic [7:0] bus_wdata = 8'h00;
   logic bus_write = 1'b0;
   logic bus_read = 1'b0;
   logic rx_char_valid = 1'b0;
   logic rx_timeout = 1'b0;
   logic stall = 1'b0;
   ufdc_pkg::ufdc_rx_char_s rx_char = '0;
   logic [7:0] bus_rdata, tx_char_data;
   logic tx_char_valid, tx_char_ready, tx_shift_busy, tx_dma_ready_n, rx_dma_ready_n;
   logic rx_data_int, tx_empty_int, line_status_int;
   logic [7:0] exp_q[$];
   integer seed = 73729;
   int error_cnt = 0;
   int n_compared = 0;

   always #10 clk = ~clk;

   ufdc_top DUT (.clk(clk), .reset_n(reset_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata),
      .rx_char_valid(rx_char_valid), .rx_char(rx_char), .rx_timeout(rx_timeout),
      .tx_char_valid(tx_char_valid), .tx_char_data(tx_char_data), .tx_char_ready(tx_char_ready),
      .tx_shift_busy(tx_shift_busy), .tx_dma_ready_n(tx_dma_ready_n), .rx_dma_ready_n(rx_dma_ready_n),
      .rx_data_int(rx_data_int), .tx_empty_int(tx_empty_int), .line_status_int(line_status_int));

   ufdc_line_model line (.clk(clk), .reset_n(reset_n), .stall(stall), .tx_char_valid(tx_char_valid),
      .tx_char_data(tx_char_data), .tx_char_ready(tx_char_ready), .tx_shift_busy(tx_shift_busy));

   ////////////////////////////////////////////////////////////////////////////////
   function automatic int rx_lvl(input int c);
      return (c == 0) ? 8 : (c == 1) ? 16 : (c == 2) ? 24 : 28;
   endfunction
   function automatic int tx_lvl(input int c);
      return (c == 0) ? 16 : (c == 1) ? 8 : (c == 2) ? 24 : 30;
   endfunction

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_write <= 1'b1;
      @(posedge clk);
      bus_write <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      bus_addr <= a;
      bus_read <= 1'b1;
      @(posedge clk);
      bus_read <= 1'b0;
      @(negedge clk);
      d = bus_rdata;
   endtask
   task automatic rx_put(input logic perr);
      logic [7:0] b;
      b = 8'($random(seed));
      @(posedge clk);
      rx_char <= {1'b0, 1'b0, perr, b};
      rx_char_valid <= 1'b1;
      @(posedge clk);
      rx_char_valid <= 1'b0;
      @(negedge clk);
      exp_q.push_back(b);
   endtask
   task automatic pop();
      logic [7:0] d;
      rd(3'h0, d);
      chk(d, exp_q.pop_front());
   endtask
   task automatic summarize();
      $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #1000000;
      error_cnt++;
      summarize();
   end

   initial begin
      logic [7:0] d;
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      @(negedge clk);
      chk({tx_dma_ready_n, rx_dma_ready_n}, 8'h01);
      rd(3'h5, d);
      chk(d, 8'h60);
      rd(3'h3, d);
      chk(d, 8'h00);
      // FIFOs on, mode left at its default, all masks clear
      wr(3'h2, 8'h01);
      rx_put(1'b0);
      chk({rx_data_int, tx_empty_int, line_status_int, rx_dma_ready_n}, 8'h00);
      rd(3'h5, d);
      chk(d, 8'h61);
      pop();
      chk(rx_dma_ready_n, 1'b1);
      // Block mode receive at every trigger code
      wr(3'h1, 8'h01);
      for (int c = 0; c < 4; c++) begin
         wr(3'h2, {2'(c), 6'h0b});
         repeat (rx_lvl(c) - 1) rx_put(1'b0);
         chk({rx_dma_ready_n, rx_data_int}, 8'h02);
         rx_put(1'b0);
         chk({rx_dma_ready_n, rx_data_int}, 8'h01);
         rx_put(1'b0);
         chk(rx_dma_ready_n, 1'b0);
         repeat (rx_lvl(c)) pop();
         chk(rx_dma_ready_n, 1'b0);
         pop();
         chk(rx_dma_ready_n, 1'b1);
      end
      wr(3'h2, 8'h0b);
      rx_put(1'b0);
      chk(rx_dma_ready_n, 1'b1);
      @(posedge clk);
      rx_timeout <= 1'b1;
      @(posedge clk);
      rx_timeout <= 1'b0;
      @(negedge clk);
      chk(rx_dma_ready_n, 1'b0);
      pop();
      // Parity error then receive clear
      wr(3'h1, 8'h04);
      wr(3'h2, 8'h07);
      rx_put(1'b1);
      chk(line_status_int, 1'b1);
      rd(3'h5, d);
      chk(d, 8'he5);
      wr(3'h2, 8'h03);
      rd(3'h6, d);
      chk(d, 8'h00);
      rd(3'h5, d);
      chk(d, 8'h60);
      exp_q.delete();
      // Enable low: mode bit ignored, single holding entry overruns
      wr(3'h2, 8'h08);
      rx_put(1'b0);
      rx_put(1'b0);
      void'(exp_q.pop_back());
      rd(3'h6, d);
      chk(d, 8'h01);
      rd(3'h5, d);
      chk(d, 8'h63);
      pop();
      // Block mode transmit with the line stalled
      wr(3'h1, 8'h02);
      @(posedge clk);
      stall <= 1'b1;
      for (int c = 0; c < 4; c++) begin
         wr(3'h2, {2'b00, 2'(c), 4'hd});
         repeat (tx_lvl(c) - 1) wr(3'h0, 8'($random(seed)));
         @(negedge clk);
         chk({tx_empty_int, tx_dma_ready_n}, 8'h02);
         wr(3'h0, 8'h5a);
         @(negedge clk);
         chk({tx_empty_int, tx_dma_ready_n}, 8'h00);
         repeat (32 - tx_lvl(c)) wr(3'h0, 8'($random(seed)));
         @(negedge clk);
         chk(tx_dma_ready_n, 1'b1);
         rd(3'h5, d);
         chk(d, 8'h00);
         wr(3'h2, {2'b00, 2'(c), 4'hd});
         rd(3'h7, d);
         chk(d, 8'h00);
         chk(tx_dma_ready_n, 1'b0);
      end
      // Mode 0 transmit drained by the line
      wr(3'h2, 8'h05);
      wr(3'h0, 8'h11);
      wr(3'h0, 8'h22);
      @(negedge clk);
      chk(tx_dma_ready_n, 1'b1);
      chk(tx_char_valid, 1'b1);
      chk(tx_char_data, 8'h11);
      @(posedge clk);
      stall <= 1'b0;
      for (int i = 0; i < 20 && tx_char_valid === 1'b1; i++) @(negedge clk);
      chk(tx_dma_ready_n, 1'b0);
      rd(3'h5, d);
      chk(d, 8'h20);
      repeat (4) @(posedge clk);
      rd(3'h5, d);
      chk(d, 8'h60);
      summarize();
   end
endmodule
